// >>> cbs_chk_asserts.sv
// Port checker for the bus-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module cbs_chk #(
  parameter [15:0] START_ADDR = 16'h0000
) (
  input wire ref_clk, srst, hardware_standby_n, rw, rd_n, wr_n, data_oe_n, ctrl_oe_n, eclk_oe_n, eclk,
  input wire addr_lo_oe_n, addr_hi_oe_n, port5_oe_n, port6_oe_n, instruction_fetch_indicator_n,
  input wire [7:0] data_in, acc_data, data_out, port5_out, port6_out,
  input wire [15:0] reg_data, addr
);
  // Short alias for the fetch indicator
  wire f_n = instruction_fetch_indicator_n;
  default clocking cb @(posedge ref_clk); endclocking
  // Standby acts like reset, so most checks rest while it is low
  default disable iff (srst || !hardware_standby_n);
  property p_rst;
    disable iff (!hardware_standby_n)
    srst |=> addr == 16'hffff && rw && rd_n && wr_n && f_n && data_oe_n && port5_oe_n && port6_oe_n && !addr_hi_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hardware_standby_n;
    disable iff (srst)
    !hardware_standby_n [*2] |-> ctrl_oe_n && eclk_oe_n && addr_lo_oe_n && addr_hi_oe_n && data_oe_n && port5_oe_n
      && port6_oe_n;
  endproperty
  a_hardware_standby_n: assert property (p_hardware_standby_n) else $error("pins driven in standby");
  property p_first;
    $past(srst) && !srst |=> addr == START_ADDR && !f_n;
  endproperty
  a_first: assert property (p_first) else $error("no fetch after reset");
  property p_ifi;
    !f_n |-> rw && !rd_n && wr_n && !addr_lo_oe_n;
  endproperty
  a_ifi: assert property (p_ifi) else $error("fetch not a read");
  property p_rdm;
    !addr_lo_oe_n && addr != 16'hffff |-> rd_n == !rw;
  endproperty
  a_rdm: assert property (p_rdm) else $error("read strobe off direction");
  property p_dead;
    !addr_lo_oe_n && addr == 16'hffff |-> rd_n && f_n;
  endproperty
  a_dead: assert property (p_dead) else $error("internal cycle strobed");
  property p_wr;
    !ctrl_oe_n |-> wr_n == rw && (rw || (rd_n && !data_oe_n && !addr_lo_oe_n));
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe off direction");
  // Processor clock toggles on every cycle once out of reset
  property p_eclk;
    $past(hardware_standby_n) && !$past(srst) |-> eclk != $past(eclk);
  endproperty
  a_eclk: assert property (p_eclk) else $error("processor clock not toggling");
  property p_std;
    !f_n && data_in == 8'hdd |=> f_n && rw && addr == $past(addr) + 16'h1
      ##1 !wr_n && !data_oe_n && addr == {8'h00, $past(data_in)} && data_out == reg_data[15:8]
      ##1 !wr_n && addr == $past(addr) + 16'h1 && data_out == reg_data[7:0] ##1 !f_n && rw;
  endproperty
  a_std: assert property (p_std) else $error("bad 16-bit store");
  property p_ldd;
    !f_n && data_in == 8'hdc |=> f_n && rw ##1 f_n && rw && addr == {8'h00, $past(data_in)}
      ##1 f_n && rw && addr == $past(addr) + 16'h1 ##1 !f_n;
  endproperty
  a_ldd: assert property (p_ldd) else $error("bad 16-bit load");
  property p_sta;
    !f_n && data_in == 8'h97 |=> f_n ##1 !wr_n && data_out == acc_data && addr == {8'h00, $past(data_in)} ##1 !f_n;
  endproperty
  a_sta: assert property (p_sta) else $error("bad 8-bit store");
  property p_keep;
    $past(hardware_standby_n) && addr_hi_oe_n && $past(addr_hi_oe_n) |-> $stable(port5_out) && $stable(port6_out)
      && $stable(port5_oe_n) && data_oe_n;
  endproperty
  a_keep: assert property (p_keep) else $error("ports moved in halt");
endmodule // cbs_chk
bind cbs_sequencer cbs_chk #(.START_ADDR(START_ADDR)) u_chk (.*);
`default_nettype wire

// >>> cbs_decode.v
// Opcode classifier for the bus-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
`include "cbs_regs.vh"
module cbs_decode (
  input wire [7:0] opcode,
  output reg [3:0] op_class,
  output reg [3:0] pref_cycles
);
  // Row and column split follows the opcode map
  wire [3:0] hi;
  wire [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  // Classify; unknown opcodes act as one-cycle inherent to keep the bus moving
  always @* begin
    op_class = `CBS_CLS_INH1;
    pref_cycles = 4'h0;
    if (opcode == `CBS_OP_MUL) begin
      op_class = `CBS_CLS_PREF;
      pref_cycles = `CBS_PREF_MUL;
    end else if (opcode == `CBS_OP_PULA || opcode == `CBS_OP_PULB) begin
      op_class = `CBS_CLS_PREF;
      pref_cycles = `CBS_PREF_PUL;
    end else if (opcode == `CBS_OP_DAA) begin
      op_class = `CBS_CLS_PREF;
      pref_cycles = `CBS_PREF_DAA;
    end else if (opcode == `CBS_OP_XCHG) begin
      op_class = `CBS_CLS_PREF;
      pref_cycles = `CBS_PREF_XCHG;
    end else if (opcode == `CBS_OP_STAA_DIR || opcode == `CBS_OP_STAB_DIR) begin
      op_class = `CBS_CLS_STA_DIR;
    end else if ((hi == 4'h9 || hi == 4'hd) && (lo == 4'hf || (hi == 4'hd && lo == 4'hd))) begin
      op_class = `CBS_CLS_STD_DIR;
    end else if ((hi == 4'h9 || hi == 4'hd) && (lo == 4'h3 || lo == 4'hc || lo == 4'he)) begin
      op_class = `CBS_CLS_DIR16;
    end else if (hi == 4'h9 || hi == 4'hd) begin
      op_class = `CBS_CLS_DIR8;
    end else if ((hi == 4'h8 || hi == 4'hc) && (lo == 4'h3 || lo == 4'hc || lo == 4'he)) begin
      op_class = `CBS_CLS_IMM16;
    end else if (hi == 4'h8 || hi == 4'hc) begin
      op_class = `CBS_CLS_IMM8;
    end
  end
endmodule // cbs_decode
`default_nettype wire

// >>> cbs_mem.sv
// Memory model on the external bus of the sequencer
`timescale 1ns/100ps
`default_nettype none
module cbs_mem (
  input wire ref_clk,
  input wire [15:0] addr,
  input wire rd_n,
  input wire wr_n,
  input wire data_oe_n,
  input wire [7:0] data_out,
  output wire [7:0] data_in
);
  reg [7:0] mem [0:255];
  reg [7:0] last_r = 8'h00;
  // Released bus flips every cycle so a stale byte never reads as valid
  assign data_in = rd_n ? ~last_r : mem[addr[7:0]];
  // Writes land at the edge that ends the strobe cycle
  always @(posedge ref_clk) begin
    last_r <= data_in;
    if (!wr_n && !data_oe_n) begin
      mem[addr[7:0]] <= data_out;
    end
  end
endmodule // cbs_mem
`default_nettype wire

// >>> cbs_regs.vh
// Constants for the bus-cycle sequencer: opcodes, cycle kinds, bus idle values
`ifndef CBS_REGS_VH
`define CBS_REGS_VH
// Address bus value for internal (dead) cycles
`define CBS_DEAD_ADDR 16'hffff
// Upper address byte driven during reset
`define CBS_RESET_ADDR_HI 8'hff
// Opcode classes decoded by the sequencer
`define CBS_CLS_IMM8 4'h0
`define CBS_CLS_IMM16 4'h1
`define CBS_CLS_DIR8 4'h2
`define CBS_CLS_DIR16 4'h3
`define CBS_CLS_STA_DIR 4'h4
`define CBS_CLS_STD_DIR 4'h5
`define CBS_CLS_INH1 4'h6
`define CBS_CLS_PREF 4'h7
// Internal cycles spent by prefetching instructions before the next fetch
`define CBS_PREF_MUL 4'h6
`define CBS_PREF_PUL 4'h2
`define CBS_PREF_DAA 4'h1
`define CBS_PREF_XCHG 4'h1
// Selected opcodes
`define CBS_OP_MUL 8'h3d
`define CBS_OP_PULA 8'h32
`define CBS_OP_PULB 8'h33
`define CBS_OP_DAA 8'h19
`define CBS_OP_XCHG 8'h18
`define CBS_OP_STAA_DIR 8'h97
`define CBS_OP_STAB_DIR 8'hd7
`endif

// >>> cbs_sequencer.v
// Bus-cycle sequencer: addresses, direction and strobes for each instruction cycle
// How it works
// - Multiply, pull, decimal_adjust and exchange_d_with_index run internal cycles after the next opcode is fetched.
// - Direct 16-bit loads take 4 cycles: address byte, high data at operand, low data at operand+1, next opcode.
// - Direct 16-bit stores take 4 cycles: address byte, write high byte, write low byte at +1, next opcode.
// - Reset drives the upper address high and floats data and ports; standby floats all; halt and sleep keep ports.
// - Hardware standby floats the processor clock output along with the other control outputs.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_regs.vh"
module cbs_sequencer #(
  parameter [15:0] START_ADDR = 16'h0000
) (
  input wire ref_clk,
  input wire srst,
  input wire hardware_standby_n,
  input wire halt_req,
  input wire sleep_req,
  input wire [7:0] data_in,
  input wire [15:0] reg_data,
  input wire [7:0] acc_data,
  input wire [7:0] port5_val,
  input wire [7:0] port6_val,
  output reg [15:0] addr,
  output wire addr_lo_oe_n,
  output wire addr_hi_oe_n,
  output reg [7:0] data_out,
  output wire data_oe_n,
  output wire rw,
  output wire rd_n,
  output wire wr_n,
  output wire instruction_fetch_indicator_n,
  output wire ctrl_oe_n,
  output wire eclk,
  output wire eclk_oe_n,
  output reg [7:0] port5_out,
  output wire port5_oe_n,
  output reg [7:0] port6_out,
  output wire port6_oe_n,
  output reg [7:0] opcode_r,
  output reg [15:0] operand_r
);
  // Sequencer states
  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_EXEC = 3'h2;
  localparam [2:0] ST_INTERNAL = 3'h3;
  localparam [2:0] ST_HALT = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] pc_r;
  reg [15:0] pc_nxt;
  reg [3:0] cyc_r;
  reg [3:0] cyc_nxt;
  reg [3:0] icnt_r;
  reg [3:0] icnt_nxt;
  reg [15:0] ea_r;
  reg [15:0] ea_nxt;
  reg [7:0] opcode_nxt;
  reg [15:0] operand_nxt;
  reg [15:0] addr_nxt;
  reg [7:0] dout_nxt;
  reg rw_r;
  reg rw_nxt;
  reg lir_r;
  reg lir_nxt;
  reg eclk_r;
  wire [3:0] op_class;
  wire [3:0] pref_cycles;
  wire [7:0] dec_op;
  wire standby;

  assign standby = ~hardware_standby_n;
  // Decode straight from the bus in the fetch cycle, from the latch afterwards
  assign dec_op = (state_r == ST_FETCH) ? data_in : opcode_r;

  cbs_decode u_dec (
    .opcode(dec_op),
    .op_class(op_class),
    .pref_cycles(pref_cycles)
  );

  // Next-cycle planning; each branch sets the bus for the cycle that follows
  always @* begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    cyc_nxt = cyc_r;
    icnt_nxt = icnt_r;
    ea_nxt = ea_r;
    opcode_nxt = opcode_r;
    operand_nxt = operand_r;
    addr_nxt = addr;
    dout_nxt = data_out;
    rw_nxt = 1'b1;
    lir_nxt = 1'b1;
    case (state_r)
      ST_RESET: begin
        state_nxt = ST_FETCH;
        pc_nxt = START_ADDR;
        addr_nxt = START_ADDR;
        lir_nxt = 1'b0;
      end
      ST_FETCH: begin
        // Opcode is on the bus now; first operand cycle reads PC+1
        opcode_nxt = data_in;
        cyc_nxt = 4'h1;
        if (op_class == `CBS_CLS_INH1 || op_class == `CBS_CLS_PREF) begin
          pc_nxt = pc_r + 16'h0001;
          addr_nxt = pc_r + 16'h0001;
          lir_nxt = 1'b0;
          icnt_nxt = pref_cycles;
          state_nxt = (op_class == `CBS_CLS_PREF) ? ST_INTERNAL : ST_FETCH;
        end else begin
          addr_nxt = pc_r + 16'h0001;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        cyc_nxt = cyc_r + 4'h1;
        state_nxt = ST_FETCH;
        lir_nxt = 1'b0;
        case (op_class)
          `CBS_CLS_IMM8: begin
            addr_nxt = pc_r + 16'h0002;
            pc_nxt = pc_r + 16'h0002;
          end
          `CBS_CLS_IMM16: begin
            if (cyc_r == 4'h1) begin
              operand_nxt = {data_in, operand_r[7:0]};
              addr_nxt = pc_r + 16'h0002;
              lir_nxt = 1'b1;
              state_nxt = ST_EXEC;
            end else begin
              operand_nxt = {operand_r[15:8], data_in};
              addr_nxt = pc_r + 16'h0003;
              pc_nxt = pc_r + 16'h0003;
            end
          end
          `CBS_CLS_DIR8, `CBS_CLS_STA_DIR: begin
            if (cyc_r == 4'h1) begin
              ea_nxt = {8'h00, data_in};
              addr_nxt = {8'h00, data_in};
              rw_nxt = (op_class != `CBS_CLS_STA_DIR);
              dout_nxt = acc_data;
              lir_nxt = 1'b1;
              state_nxt = ST_EXEC;
            end else begin
              if (op_class == `CBS_CLS_DIR8) begin
                operand_nxt = {8'h00, data_in};
              end
              addr_nxt = pc_r + 16'h0002;
              pc_nxt = pc_r + 16'h0002;
            end
          end
          default: begin
            // direct 16-bit loads and direct 16-bit stores share the walk
            lir_nxt = 1'b1;
            state_nxt = ST_EXEC;
            if (cyc_r == 4'h1) begin
              ea_nxt = {8'h00, data_in};
              addr_nxt = {8'h00, data_in};
              rw_nxt = (op_class == `CBS_CLS_DIR16);
              dout_nxt = reg_data[15:8];
            end else if (cyc_r == 4'h2) begin
              // low byte to destination + 1
              operand_nxt = {data_in, operand_r[7:0]};
              addr_nxt = ea_r + 16'h0001;
              rw_nxt = (op_class == `CBS_CLS_DIR16);
              dout_nxt = reg_data[7:0];
            end else begin
              operand_nxt = {operand_r[15:8], data_in};
              addr_nxt = pc_r + 16'h0002;
              pc_nxt = pc_r + 16'h0002;
              lir_nxt = 1'b0;
              state_nxt = ST_FETCH;
            end
          end
        endcase
      end
      ST_INTERNAL: begin
        // One dead cycle per count after the prefetch, then the opcode is fetched again
        if (icnt_r == 4'h0) begin
          addr_nxt = pc_r;
          lir_nxt = 1'b0;
          state_nxt = ST_FETCH;
        end else begin
          addr_nxt = `CBS_DEAD_ADDR;
          icnt_nxt = icnt_r - 4'h1;
        end
      end
      ST_HALT: begin
        if (!halt_req && !sleep_req) begin
          addr_nxt = pc_r;
          lir_nxt = 1'b0;
          state_nxt = ST_FETCH;
        end
      end
      default: state_nxt = ST_RESET;
    endcase
    // Halt and sleep are honoured only at an instruction boundary
    if (state_r == ST_FETCH && state_nxt == ST_FETCH && (halt_req || sleep_req)) begin
      state_nxt = ST_HALT;
      lir_nxt = 1'b1;
    end
  end

  // Registered bus state
  always @(posedge ref_clk) begin
    if (srst || standby) begin
      state_r <= ST_RESET;
      pc_r <= 16'h0000;
      cyc_r <= 4'h0;
      icnt_r <= 4'h0;
      ea_r <= 16'h0000;
      opcode_r <= 8'h00;
      operand_r <= 16'h0000;
      addr <= {`CBS_RESET_ADDR_HI, 8'hff};
      data_out <= 8'h00;
      rw_r <= 1'b1;
      lir_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      cyc_r <= cyc_nxt;
      icnt_r <= icnt_nxt;
      ea_r <= ea_nxt;
      opcode_r <= opcode_nxt;
      operand_r <= operand_nxt;
      addr <= addr_nxt;
      data_out <= dout_nxt;
      rw_r <= rw_nxt;
      lir_r <= lir_nxt;
    end
  end

  // Processor clock out, one toggle per cycle; stops in standby
  always @(posedge ref_clk) begin
    if (srst || standby) begin
      eclk_r <= 1'b0;
    end else begin
      eclk_r <= ~eclk_r;
    end
  end

  // Ports keep last value in halt and sleep since the latch just stops loading
  always @(posedge ref_clk) begin
    if (srst) begin
      port5_out <= 8'h00;
      port6_out <= 8'h00;
    end else if (state_r != ST_HALT && state_r != ST_RESET) begin
      port5_out <= port5_val;
      port6_out <= port6_val;
    end
  end

  // pin float map for reset, standby and halt
  assign addr_lo_oe_n = standby | (state_r == ST_HALT);
  assign addr_hi_oe_n = standby | (state_r == ST_HALT);
  assign data_oe_n = standby | (state_r == ST_RESET) | (state_r == ST_HALT) | rw_r;
  assign port5_oe_n = standby | srst | (state_r == ST_RESET);
  assign port6_oe_n = standby | srst | (state_r == ST_RESET);
  // clock and control pins float in standby
  assign ctrl_oe_n = standby;
  assign eclk_oe_n = standby;
  assign eclk = eclk_r;
  // strobes from direction; indicator only on opcode fetch
  assign rw = rw_r;
  assign rd_n = ~rw_r | (state_r == ST_RESET) | (state_r == ST_HALT) | (addr == `CBS_DEAD_ADDR);
  assign wr_n = rw_r;
  assign instruction_fetch_indicator_n = lir_r;
endmodule // cbs_sequencer
`default_nettype wire

// >>> cbs_tb.sv
// Self-checking bench for the bus-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg hardware_standby_n = 1'b1;
  reg halt_req = 1'b0;
  reg sleep_req = 1'b0;
  reg [15:0] reg_data = 16'h0000;
  reg [7:0] acc_data = 8'h00;
  reg [7:0] port5_val = 8'h3c;
  reg [7:0] port6_val = 8'hc3;
  wire [7:0] data_in, data_out, port5_out, port6_out;
  wire [15:0] addr;
  wire addr_lo_oe_n, addr_hi_oe_n, data_oe_n, rw, rd_n, wr_n, ctrl_oe_n, eclk_oe_n, port5_oe_n, port6_oe_n;
  wire instruction_fetch_indicator_n;
  wire eclk;
  wire [7:0] opcode_r;
  wire [15:0] operand_r;
  wire f_n = instruction_fetch_indicator_n;
  integer err_count = 0;
  integer cmp_count = 0;
  integer i, k, n;
  reg [15:0] lf = 16'h945d;
  reg [7:0] ea;
  cbs_sequencer u_dut (.*);
  cbs_mem u_mem (.*);
  // Free-running system clock
  always #12.5 ref_clk = ~ref_clk;
  // Shift register step for repeatable stimulus
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Bus address in each cycle of the direct 16-bit load placed at 4
  function [15:0] ldd_addr(input integer c, input [7:0] a);
    ldd_addr = (c == 1) ? 16'h0005 : (c == 2) ? {8'h00, a} : (c == 3) ? {8'h00, a} + 16'h1 : 16'h0006;
  endfunction
  // Prefetching opcodes and their internal cycle counts
  function [7:0] op_at(input integer j);
    op_at = (j == 0) ? 8'h3d : (j == 1) ? 8'h32 : (j == 2) ? 8'h33 : (j == 3) ? 8'h19 : 8'h18;
  endfunction
  function integer dead_n(input [7:0] op);
    dead_n = (op == 8'h3d) ? 6 : (op[7:4] == 4'h3) ? 2 : 1;
  endfunction
  task tally_and_finish;
    begin
      if (err_count == 0 && cmp_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Inputs always move 2 ns after the edge
  task cyc(input integer c);
    begin
      repeat (c) @(posedge ref_clk);
      #2;
    end
  endtask
  task fill;
    begin
      for (i = 0; i < 256; i = i + 1) begin
        u_mem.mem[i] = 8'h01;
      end
    end
  endtask
  task boot;
    begin
      srst = 1'b1;
      cyc(8);
      chk({addr, rd_n, wr_n, f_n, data_oe_n, port5_oe_n, addr_hi_oe_n}, {16'hffff, 6'b111110});
      srst = 1'b0;
      cyc(1);
      chk({addr, f_n, eclk}, {16'h0000, 2'b01});
    end
  endtask
  // Cycles from the current fetch to the fetch at a; a hang ends the run
  task wait_fetch(input [15:0] a);
    begin
      n = 0;
      while ((f_n !== 1'b0 || addr !== a || n == 0) && n < 40) begin
        cyc(1);
        n = n + 1;
      end
      if (f_n !== 1'b0 || addr !== a) begin
        err_count = err_count + 1;
        tally_and_finish;
      end
    end
  endtask
  initial begin
    // Store 16, store 8, load 16; first pass uses the top of the page
    for (k = 0; k < 6; k = k + 1) begin
      lf = lfsr(lf);
      ea = (k == 0) ? 8'hfd : {2'b01, lf[13:8]};
      reg_data = (k == 0) ? 16'h8001 : lf;
      acc_data = lf[7:0];
      fill;
      u_mem.mem[0] = 8'hdd;
      u_mem.mem[1] = ea;
      u_mem.mem[2] = 8'h97;
      u_mem.mem[3] = ea + 8'h02;
      u_mem.mem[4] = 8'hdc;
      u_mem.mem[5] = ea;
      u_mem.mem[6] = 8'h86;
      u_mem.mem[8] = 8'hcc;
      u_mem.mem[9] = reg_data[7:0];
      u_mem.mem[10] = reg_data[15:8];
      u_mem.mem[11] = 8'h96;
      u_mem.mem[12] = ea;
      boot;
      wait_fetch(16'h0002);
      chk(n, 4);
      wait_fetch(16'h0004);
      chk(n, 3);
      for (i = 1; i < 5; i = i + 1) begin
        cyc(1);
        chk({addr, f_n}, {ldd_addr(i, ea), i != 4});
      end
      chk({opcode_r, operand_r}, {8'hdc, reg_data});
      chk(u_mem.mem[ea], reg_data[15:8]);
      chk(u_mem.mem[ea + 8'h01], reg_data[7:0]);
      chk(u_mem.mem[ea + 8'h02], acc_data);
      // Immediate 8, immediate 16 and direct 8 spacing; latched operands of immediate 16 and direct 8
      wait_fetch(16'h0008);
      chk(n, 2);
      wait_fetch(16'h000b);
      chk(n, 3);
      chk(operand_r, {reg_data[7:0], reg_data[15:8]});
      wait_fetch(16'h000d);
      chk(n, 3);
      chk(operand_r, {8'h00, reg_data[15:8]});
    end
    // Prefetching instructions show their internal cycles
    for (k = 0; k < 5; k = k + 1) begin
      fill;
      u_mem.mem[0] = op_at(k);
      boot;
      n = 0;
      for (i = 0; i < 16; i = i + 1) begin
        cyc(1);
        n = n + (addr === 16'hffff);
      end
      chk(n, dead_n(op_at(k)));
    end
    // Halt then sleep: ports keep their value while the input moves
    for (k = 0; k < 2; k = k + 1) begin
      fill;
      port5_val = 8'h3c;
      port6_val = 8'hc3;
      boot;
      cyc(4);
      halt_req = (k == 0);
      sleep_req = (k == 1);
      n = 0;
      while (addr_hi_oe_n !== 1'b1 && n < 40) begin
        cyc(1);
        n = n + 1;
      end
      if (addr_hi_oe_n !== 1'b1) begin
        err_count = err_count + 1;
        tally_and_finish;
      end
      port5_val = 8'h99;
      port6_val = 8'h66;
      cyc(3);
      chk({addr_lo_oe_n, data_oe_n, port5_out, port6_out, port5_oe_n, port6_oe_n}, {2'b11, 8'h3c, 8'hc3, 2'b00});
      halt_req = 1'b0;
      sleep_req = 1'b0;
    end
    // Standby floats every output
    hardware_standby_n = 1'b0;
    cyc(2);
    chk({ctrl_oe_n, eclk_oe_n, addr_lo_oe_n, addr_hi_oe_n, data_oe_n, port5_oe_n, port6_oe_n}, 7'h7f);
    hardware_standby_n = 1'b1;
    boot;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
